// file: design/wds_top.sv
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
// Functional notes
// - writing 0x55 to the service register arms the sequence
// - writing 0xaa after arming completes service and restarts the time-out
// - other accesses between the two writes do not break the sequence
// - time-out before a completed 0x55 then 0xaa pair forces a reset
// - any other value written to the service register forces a reset at once
// - in windowed mode completion before the last quarter forces a reset
// - windowed mode allows repeated 0x55; after 0xaa wait for next window
// - three-bit rate selects power-of-two time-out; zero switches the watchdog off
// - reset-suppress blocks every new watchdog reset; one already running when it is set runs to its end
module wds_top
   import wds_pkg::*;
(
   input  wire logic       MCLK_I,
   input  wire logic       SYS_RST_I,
   input  wire logic       CRYSTAL_TICK_I,
   input  wire logic [7:0] ADDR_I,
   input  wire logic [7:0] WDATA_I,
   input  wire logic       WR_I,
   input  wire logic       RD_I,
   output logic      [7:0] RDATA_O,
   output logic            WDOG_RST_O,
   output logic            TIMEOUT_O
);
   import wds_pkg::*;

   logic             tick;
   logic             tick_q;
   wds_svc_t         state_q;
   wds_svc_t         state_d;
   logic [2:0]       rate_q;
   logic             window_q;
   logic             suppress_q;
   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] limit;
   logic [CNT_W-1:0] win_start;
   logic [2:0]       pulse_q;
   logic             fault_q;

   // crystal tick arrives from another domain
   wds_sync u_tick_sync (
      .clk_i (MCLK_I),
      .rst_i (SYS_RST_I),
      .d_i   (CRYSTAL_TICK_I),
      .q_o   (tick)
   );
   // edge detector resets to the idle level of the tick, no false edge after reset
   always_ff @(posedge MCLK_I) begin
      if (SYS_RST_I) begin
         tick_q <= 1'b0;
      end else begin
         tick_q <= tick;
      end
   end
   wire tick_edge = tick & ~tick_q;

   wire svc_wr    = WR_I && (ADDR_I == SERVICE_OFFSET);
   wire ctl_wr    = WR_I && (ADDR_I == CONTROL_OFFSET);
   wire enabled   = (rate_q != 3'h0);
   wire arm_wr    = svc_wr && (WDATA_I == ARM_VALUE);
   wire done_wr   = svc_wr && (WDATA_I == RESTART_VALUE);
   wire bad_wr    = svc_wr && !arm_wr && !done_wr;

   // window edges ignore prescaler phase; the usable window is slightly narrower in silicon
   assign limit     = CNT_W'(1) << (RATE_BASE_SHIFT + int'(rate_q));
   assign win_start = limit - (limit >> 2);
   wire in_window   = (cnt_q >= win_start);
   wire early       = window_q && !in_window;
   wire expired     = enabled && tick_edge && (cnt_q == limit - CNT_W'(1));
   // a complete needs prior arming; idle 0xaa is a sequence fault
   wire complete    = done_wr && (state_q == SVC_ARMED) && !early;
   wire seq_fault   = enabled && (bad_wr || (svc_wr && early)
                      || (done_wr && state_q != SVC_ARMED) || expired);

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         SVC_IDLE:  if (arm_wr) state_d = SVC_ARMED;
         SVC_ARMED: if (done_wr) state_d = SVC_IDLE;
      endcase
   end

   always_ff @(posedge MCLK_I) begin
      if (SYS_RST_I) begin
         state_q <= SVC_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge MCLK_I) begin
      if (SYS_RST_I) begin
         rate_q     <= RATE_RESET;
         window_q   <= 1'b0;
         suppress_q <= 1'b0;
      end else if (ctl_wr) begin
         rate_q     <= WDATA_I[WDOG_RATE_LSB +: 3];
         window_q   <= WDATA_I[WDOG_WINDOW_BIT];
         suppress_q <= WDATA_I[WDOG_SUPPRESS_BIT];
      end
   end

   always_ff @(posedge MCLK_I) begin
      // expiry restarts the count so a missed service fires again each period
      if (SYS_RST_I || complete || !enabled || expired) begin
         cnt_q <= '0;
      end else if (tick_edge) begin
         cnt_q <= cnt_q + CNT_W'(1);
      end
   end

   // stretched reset pulse; suppress blocks a new one, a pulse already running counts down to its end
   always_ff @(posedge MCLK_I) begin
      if (SYS_RST_I) begin
         pulse_q <= 3'h0;
         fault_q <= 1'b0;
      end else begin
         fault_q <= seq_fault;
         if (seq_fault && !suppress_q) pulse_q <= 3'(RST_PULSE_CYCLES);
         else if (pulse_q != 3'h0) pulse_q <= pulse_q - 3'h1;
      end
   end

   assign WDOG_RST_O = (pulse_q != 3'h0);
   assign TIMEOUT_O  = fault_q;

   // service register always reads zero; control reads back
   always_ff @(posedge MCLK_I) begin
      if (SYS_RST_I) RDATA_O <= SERVICE_RESET;
      else if (RD_I && ADDR_I == CONTROL_OFFSET)
         RDATA_O <= {3'h0, window_q, suppress_q, rate_q};
      else RDATA_O <= SERVICE_RESET;
   end

   a_bad_value_resets: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
      (bad_wr && enabled && !suppress_q) |=> WDOG_RST_O [*4])
      else $error("bad service value gave no reset");
   a_suppress_holds: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
      (suppress_q && !WDOG_RST_O) |=> !WDOG_RST_O || !$stable(suppress_q) || $past(ctl_wr))
      else $error("reset while suppressed");
   a_complete_restarts: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
      complete |=> (cnt_q == '0) && state_q == SVC_IDLE)
      else $error("completion did not restart count");
   a_arm_step: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
      (arm_wr && state_q == SVC_IDLE) |=> state_q == SVC_ARMED)
      else $error("arming not taken");
   a_off_no_fault: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
      !enabled |=> !fault_q)
      else $error("fault while watchdog off");
   a_timeout_resets: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
      (expired && !suppress_q) |=> ##[0:1] WDOG_RST_O)
      else $error("time-out gave no reset");
   a_early_window: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
      (svc_wr && window_q && !in_window && enabled) |=> fault_q)
      else $error("early write not flagged");
   a_idle_after_reset: assert property (@(posedge MCLK_I)
      SYS_RST_I |=> state_q == SVC_IDLE)
      else $error("arming survived reset");

   // multi-step service behaviour shared by the checks below
   sequence s_good_done;
      done_wr && state_q == SVC_ARMED && !early && !expired;
   endsequence

   sequence s_long_pulse;
      WDOG_RST_O [*4];
   endsequence

   sequence s_restarted;
      cnt_q == '0 && state_q == SVC_IDLE && !in_window;
   endsequence

   a_pair_restarts: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
      s_good_done |=> s_restarted)
      else $error("completed pair did not restart");

   a_pair_no_fault: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
      s_good_done |=> !fault_q)
      else $error("good pair flagged as fault");

   a_armed_stays: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
      (state_q == SVC_ARMED && !done_wr) |=> state_q == SVC_ARMED)
      else $error("arming lost between writes");

   a_idle_done_fault: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
      (done_wr && state_q == SVC_IDLE && enabled) |=> fault_q)
      else $error("unarmed completion not flagged");

   a_timeout_flag: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
      expired |=> fault_q)
      else $error("expiry not flagged");

   a_fault_pulse: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
      (seq_fault && !suppress_q) |=> s_long_pulse)
      else $error("reset request shorter than four cycles");

   a_fault_reported: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
      (bad_wr && enabled) |=> fault_q)
      else $error("bad value not reported");

   a_window_rearm: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
      (arm_wr && window_q && in_window && enabled && !expired) |=> !fault_q)
      else $error("repeated arming in window flagged");

   a_off_no_count: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
      !enabled |=> cnt_q == '0)
      else $error("counter ran while off");

   a_suppressed_quiet: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
      (suppress_q && !WDOG_RST_O) |=> !WDOG_RST_O)
      else $error("reset request while suppressed");

   a_reset_quiet: assert property (@(posedge MCLK_I)
      SYS_RST_I |=> !WDOG_RST_O && !fault_q && state_q == SVC_IDLE)
      else $error("outputs active after reset");

   a_service_reads_zero: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
      (RD_I && ADDR_I == SERVICE_OFFSET) |=> RDATA_O == SERVICE_RESET)
      else $error("service register read not zero");
endmodule

// file: design/wds_pkg.sv
package wds_pkg;
   localparam logic [7:0] SERVICE_OFFSET   = 8'h17;
   localparam logic [7:0] CONTROL_OFFSET   = 8'h16;
   localparam logic [7:0] ARM_VALUE        = 8'h55;
   localparam logic [7:0] RESTART_VALUE    = 8'haa;
   localparam logic [7:0] SERVICE_RESET    = 8'h00;
   localparam int         WDOG_RATE_LSB    = 0;
   localparam int         WDOG_SUPPRESS_BIT = 3;
   localparam int         WDOG_WINDOW_BIT  = 4;
   localparam logic [2:0] RATE_RESET       = 3'h7;
   localparam int         RATE_BASE_SHIFT  = 12;
   localparam int         CNT_W            = 24;
   localparam int         RST_PULSE_CYCLES = 4;
   typedef enum logic [1:0] {SVC_IDLE, SVC_ARMED} wds_svc_t;
endpackage

// file: design/wds_sync.sv
`timescale 1ns/1ps
module wds_sync (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic d_i,
   output logic      q_o
);
   logic s1_q;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s1_q <= 1'b0;
         q_o  <= 1'b0;
      end else begin
         s1_q <= d_i;
         q_o  <= s1_q;
      end
   end
endmodule

// file: tb/wds_top_bench.sv
`timescale 1ns/1ps
module wds_top_bench;
   import wds_pkg::*;
   logic       clk = 0, rst = 1, tick = 0, ten = 0, wr = 0, rd = 0;
   logic [7:0] addr = 0, wd = 0, rdat, b;
   logic       wrst, tmo;
   int         error_cnt = 0, checks_done = 0, n;
   always #20 clk = ~clk;
   // one tick rise every two cycles, only while enabled
   always @(posedge clk) tick <= ten & ~tick;
   wds_top wds_top_inst (.MCLK_I(clk), .SYS_RST_I(rst), .CRYSTAL_TICK_I(tick), .ADDR_I(addr), .WDATA_I(wd),
      .WR_I(wr), .RD_I(rd), .RDATA_O(rdat), .WDOG_RST_O(wrst), .TIMEOUT_O(tmo));
   task test_done;
      if (error_cnt == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task chk(input logic [7:0] s, input logic [7:0] e);
      checks_done++;
      if (s !== e) begin
         error_cnt++;
         $display("Error %0t: saw %h want %h", $time, s, e);
      end
   endtask
   task wrr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wd <= d;
      wr <= 1;
      @(posedge clk);
      wr <= 0;
      #1;
   endtask
   task rdc(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1;
      @(posedge clk);
      rd <= 0;
      #1;
      chk(rdat, e);
   endtask
   // service write, then fault pulse and four-cycle reset request
   task svc(input logic [7:0] d, input logic f, input logic r);
      wrr(SERVICE_OFFSET, d);
      chk({6'h0, tmo, wrst}, {6'h0, f, r});
      repeat (3) begin
         @(posedge clk);
         #1;
         chk({7'h0, wrst}, {7'h0, r});
      end
      @(posedge clk);
      #1;
      chk({7'h0, wrst}, 8'h00);
   endtask
   task do_rst;
      @(posedge clk);
      rst <= 1;
      repeat (3) @(posedge clk);
      rst <= 0;
   endtask
   initial begin
      void'($urandom(32'hc3823576));
      do_rst();
      rdc(CONTROL_OFFSET, {5'h0, RATE_RESET});
      rdc(SERVICE_OFFSET, SERVICE_RESET);
      rdc(8'h20, 8'h00);
      svc(ARM_VALUE, 0, 0);
      rdc(CONTROL_OFFSET, {5'h0, RATE_RESET});
      svc(RESTART_VALUE, 0, 0);
      svc(RESTART_VALUE, 1, 1);
      for (int i = 0; i < 6; i++) begin
         b = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
         if (b == ARM_VALUE || b == RESTART_VALUE)
            b = 8'h54;
         svc(b, 1, 1);
      end
      svc(ARM_VALUE, 0, 0);
      do_rst();
      svc(RESTART_VALUE, 1, 1);
      wrr(CONTROL_OFFSET, 8'h0f);
      svc(8'h12, 1, 0);
      wrr(CONTROL_OFFSET, 8'h00);
      svc(8'h12, 0, 0);
      wrr(CONTROL_OFFSET, 8'h11);
      svc(ARM_VALUE, 1, 1);
      wrr(CONTROL_OFFSET, 8'h01);
      svc(ARM_VALUE, 0, 0);
      svc(RESTART_VALUE, 0, 0);
      ten <= 1;
      n = 0;
      // rate 1 gives 2^13 ticks, about 16384 cycles plus sync delay
      while (tmo !== 1'b1 && n < 20000) begin
         @(posedge clk);
         #1;
         n++;
      end
      ten <= 0;
      chk({7'h0, n > 16300 && n < 16500}, 8'h01);
      chk({7'h0, wrst}, 8'h01);
      // windowed: about 6250 ticks lands in the last quarter of 8192
      wrr(CONTROL_OFFSET, 8'h11);
      ten <= 1;
      repeat (12500) @(posedge clk);
      svc(ARM_VALUE, 0, 0);
      svc(ARM_VALUE, 0, 0);
      svc(RESTART_VALUE, 0, 0);
      svc(ARM_VALUE, 1, 1);
      ten <= 0;
      test_done();
   end
endmodule
